// ### design/rxq_consts.svh
// register offsets, field positions and reset values of the receive control bank
`ifndef RXQ_CONSTS_SVH
`define RXQ_CONSTS_SVH

`define RXQ_OFS_BOOST 8'h03
`define RXQ_OFS_LOW_RATE 8'h0d
`define RXQ_OFS_BYP_PD 8'h13
`define RXQ_OFS_OVERRIDE 8'h2d
`define RXQ_OFS_DELIVERED 8'h52
`define RXQ_OFS_IRQ_STATUS 8'h54
`define RXQ_OFS_IRQ_ENABLE 8'h56
`define RXQ_OFS_CHAN_CTRL 8'hff

`define RXQ_RST_BOOST 8'h80
`define RXQ_RST_LOW_RATE 8'h00
`define RXQ_RST_BYP_PD 8'h90
`define RXQ_RST_OVERRIDE 8'h88
`define RXQ_RST_IRQ_ENABLE 8'h00
`define RXQ_RST_CHAN_CTRL 8'h00

`define RXQ_BIT_CDR_LOCK 6
`define RXQ_BIT_DET1 5
`define RXQ_BIT_DET0 4
`define RXQ_BIT_EYE 3
`define RXQ_BIT_CDR_LOSS 2
`define RXQ_BIT_LOSS1 1
`define RXQ_BIT_LOSS0 0
`define RXQ_BIT_SIGDET_LIVE 7

`define RXQ_BIT_AUTO_BYPASS 0
`define RXQ_BIT_DET0_PD 6
`define RXQ_BIT_DET1_PD 5
`define RXQ_BIT_EQ_PD 3
`define RXQ_BIT_LATE_BYPASS 1
`define RXQ_BIT_BOOST_OVR 3
`define RXQ_BIT_LOS_SEL 5

`define RXQ_FRAME_BITS 5'd16
`define RXQ_ADDR_DONE 5'd8

`endif

// ### design/rxq_pkg.sv
// state types of the receive control bank and its serial port
`default_nettype none
package rxq_pkg;

	typedef struct packed
	{
		logic sclk_q;
		logic [4:0] cnt;
		logic [15:0] sh_in;
		logic [7:0] sh_out;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
		logic wr_pulse;
		logic rd_pulse;
		logic miso;
		logic miso_oe;
	} rxq_spi_state_t;

	typedef struct packed
	{
		logic [7:0] boost;
		logic [7:0] low_rate;
		logic [7:0] byp_pd;
		logic [7:0] override;
		logic [7:0] irq_en;
		logic [7:0] chan_ctrl;
		logic [6:0] flags;
		logic cdr_q;
		logic det0_q;
		logic det1_q;
		logic eye_q;
		logic [7:0] delivered;
		logic full_bypass;
		logic late_bypass;
		logic det0_pd;
		logic det1_pd;
		logic eq0_pd;
		logic eq1_pd;
		logic irq;
		logic los;
	} rxq_state_t;

endpackage
`default_nettype wire

// ### design/rxq_spi_slave.sv
// serial management port: 16-bit frames, read flag, 7-bit address, data
`timescale 1ns/10ps
`default_nettype none
`include "rxq_consts.svh"

module rxq_spi_slave
	import rxq_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic [7:0] rd_data,
	output logic rd_pulse,
	output logic wr_pulse,
	output logic [6:0] addr,
	output logic [7:0] wdata
);

	rxq_spi_state_t s_reg;
	rxq_spi_state_t s_next;

	logic rise;
	logic fall;
	logic [15:0] shifted;

	// ------------------------------------------------------------
	// frame decode
	// ------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.sclk_q = sclk;
		s_next.wr_pulse = 1'b0;
		s_next.rd_pulse = 1'b0;
		rise = sclk & ~s_reg.sclk_q;
		fall = ~sclk & s_reg.sclk_q;
		shifted = {s_reg.sh_in[14:0], mosi};
		if (ss_n)
		begin
			s_next.cnt = 5'd0;
			s_next.miso_oe = 1'b0;
			s_next.miso = 1'b0;
		end
		else
		begin
			if (rise && s_reg.cnt < `RXQ_FRAME_BITS)
			begin
				s_next.sh_in = shifted;
				s_next.cnt = s_reg.cnt + 5'd1;
				if (s_reg.cnt == `RXQ_ADDR_DONE - 5'd1)
				begin
					s_next.rd = shifted[7];
					s_next.addr = shifted[6:0];
					s_next.rd_pulse = shifted[7];
				end
				if (s_reg.cnt == `RXQ_FRAME_BITS - 5'd1 && !s_reg.rd)
				begin
					s_next.wdata = shifted[7:0];
					s_next.wr_pulse = 1'b1;
				end
			end
			// read data is latched the cycle after the address completes
			if (s_reg.rd_pulse)
			begin
				s_next.sh_out = rd_data;
				s_next.miso = rd_data[7];
				s_next.miso_oe = 1'b1;
			end
			// no shift on the falling edge of the last address bit
			else if (fall && s_reg.miso_oe && s_reg.cnt > `RXQ_ADDR_DONE)
			begin
				s_next.sh_out = {s_reg.sh_out[6:0], 1'b0};
				s_next.miso = s_reg.sh_out[6];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign miso = s_reg.miso;
	assign miso_oe = s_reg.miso_oe;
	assign rd_pulse = s_reg.rd_pulse;
	assign wr_pulse = s_reg.wr_pulse;
	assign addr = s_reg.addr;
	assign wdata = s_reg.wdata;

endmodule
`default_nettype wire

// ### design/rxq_regs.sv
// receive equalizer control and interrupt mask register bank
`timescale 1ns/10ps
`default_nettype none
`include "rxq_consts.svh"

module rxq_regs
	import rxq_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic cdr_locked,
	input wire logic input0_signal_detect,
	input wire logic input1_signal_detect,
	input wire logic eye_threshold_reached,
	input wire logic selected_input,
	input wire logic low_rate_detected,
	input wire logic adapt_running,
	input wire logic [7:0] adapt_boost,
	output logic [7:0] boost_to_eq,
	output logic eq_full_bypass,
	output logic late_stage_bypass,
	output logic input0_detector_powerdown,
	output logic input1_detector_powerdown,
	output logic input0_eq_powerdown,
	output logic input1_eq_powerdown,
	output logic irq,
	output logic los_pin
);

	rxq_state_t s_reg;
	rxq_state_t s_next;

	logic rd_pulse;
	logic wr_pulse;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rd_data;
	logic [7:0] full_addr;
	logic [6:0] events;
	logic sigdet_sel;
	logic status_read;

	// ------------------------------------------------------------
	// serial port
	// ------------------------------------------------------------
	rxq_spi_slave u_port (
		.clk(clk),
		.arst_n(arst_n),
		.sclk(sclk),
		.ss_n(ss_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe(miso_oe),
		.rd_data(rd_data),
		.rd_pulse(rd_pulse),
		.wr_pulse(wr_pulse),
		.addr(addr),
		.wdata(wdata)
	);

	assign full_addr = {1'b0, addr};

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb
	begin
		sigdet_sel = selected_input ? input1_signal_detect
			: input0_signal_detect;
		unique case (full_addr)
			`RXQ_OFS_BOOST:
				rd_data = s_reg.boost;
			`RXQ_OFS_LOW_RATE:
				rd_data = s_reg.low_rate;
			`RXQ_OFS_BYP_PD:
				rd_data = s_reg.byp_pd;
			`RXQ_OFS_OVERRIDE:
				rd_data = s_reg.override;
			`RXQ_OFS_DELIVERED:
				rd_data = s_reg.delivered;
			// live detect on top of sticky flags
			`RXQ_OFS_IRQ_STATUS:
				rd_data = {sigdet_sel, s_reg.flags};
			`RXQ_OFS_IRQ_ENABLE:
				rd_data = s_reg.irq_en;
			// seven address bits reach 0x7f at most, so the top bit drops
			(`RXQ_OFS_CHAN_CTRL & 8'h7f):
				rd_data = s_reg.chan_ctrl;
			default:
				rd_data = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.cdr_q = cdr_locked;
		s_next.det0_q = input0_signal_detect;
		s_next.det1_q = input1_signal_detect;
		s_next.eye_q = eye_threshold_reached;

		events = '0;
		events[`RXQ_BIT_CDR_LOCK] = cdr_locked & ~s_reg.cdr_q;
		events[`RXQ_BIT_DET1] = input1_signal_detect & ~s_reg.det1_q;
		events[`RXQ_BIT_DET0] = input0_signal_detect & ~s_reg.det0_q;
		events[`RXQ_BIT_EYE] = eye_threshold_reached & ~s_reg.eye_q;
		events[`RXQ_BIT_CDR_LOSS] = ~cdr_locked & s_reg.cdr_q;
		events[`RXQ_BIT_LOSS1] = ~input1_signal_detect & s_reg.det1_q;
		events[`RXQ_BIT_LOSS0] = ~input0_signal_detect & s_reg.det0_q;

		// read clears, a same-cycle event still sets
		status_read = rd_pulse && full_addr == `RXQ_OFS_IRQ_STATUS;
		s_next.flags = (status_read ? 7'h00 : s_reg.flags) | events;

		if (wr_pulse)
		begin
			unique case (full_addr)
				`RXQ_OFS_BOOST:
					s_next.boost = wdata;
				`RXQ_OFS_LOW_RATE:
					s_next.low_rate = wdata;
				`RXQ_OFS_BYP_PD:
					s_next.byp_pd = wdata;
				`RXQ_OFS_OVERRIDE:
					s_next.override = wdata;
				`RXQ_OFS_IRQ_ENABLE:
					s_next.irq_en = wdata;
				(`RXQ_OFS_CHAN_CTRL & 8'h7f):
					s_next.chan_ctrl = wdata;
				default:
					s_next.chan_ctrl = s_reg.chan_ctrl;
			endcase
		end

		// adaptation wins over a software write
		if (adapt_running)
			s_next.boost = adapt_boost;

		// written boost used only under override
		s_next.delivered = s_next.override[`RXQ_BIT_BOOST_OVR]
			? s_next.boost : adapt_boost;

		s_next.late_bypass = s_next.byp_pd[`RXQ_BIT_LATE_BYPASS];
		// auto bypass only at the low rate
		s_next.full_bypass = s_next.low_rate[`RXQ_BIT_AUTO_BYPASS]
			& low_rate_detected & ~s_next.late_bypass;

		s_next.det0_pd = s_next.byp_pd[`RXQ_BIT_DET0_PD];
		s_next.det1_pd = s_next.byp_pd[`RXQ_BIT_DET1_PD];
		s_next.eq0_pd = selected_input ? 1'b1
			: s_next.byp_pd[`RXQ_BIT_EQ_PD];
		s_next.eq1_pd = selected_input ? s_next.byp_pd[`RXQ_BIT_EQ_PD]
			: 1'b1;

		// any enabled flag raises the interrupt
		s_next.irq = |(s_next.flags & s_next.irq_en[6:0]);
		// pin carries interrupt or loss indication
		s_next.los = s_next.chan_ctrl[`RXQ_BIT_LOS_SEL] ? s_next.irq
			: ~sigdet_sel;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_reg <= '0;
			s_reg.boost <= `RXQ_RST_BOOST;
			s_reg.low_rate <= `RXQ_RST_LOW_RATE;
			// reserved bits 7 and 4 come up set
			s_reg.byp_pd <= `RXQ_RST_BYP_PD;
			s_reg.override <= `RXQ_RST_OVERRIDE;
			s_reg.irq_en <= `RXQ_RST_IRQ_ENABLE;
			s_reg.chan_ctrl <= `RXQ_RST_CHAN_CTRL;
			s_reg.delivered <= `RXQ_RST_BOOST;
			s_reg.eq1_pd <= 1'b1;
			s_reg.los <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign late_stage_bypass = s_reg.late_bypass;
	assign boost_to_eq = s_reg.delivered;
	assign eq_full_bypass = s_reg.full_bypass;
	assign input0_detector_powerdown = s_reg.det0_pd;
	assign input1_detector_powerdown = s_reg.det1_pd;
	assign input0_eq_powerdown = s_reg.eq0_pd;
	assign input1_eq_powerdown = s_reg.eq1_pd;
	assign irq = s_reg.irq;
	assign los_pin = s_reg.los;

endmodule
`default_nettype wire

// ### test/rxq_regs_asserts.sv
// port checks for the receive control bank
`timescale 1ns/10ps
`default_nettype none

module rxq_regs_asserts
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ss_n,
	input wire logic selected_input,
	input wire logic low_rate_detected,
	input wire logic adapt_running,
	input wire logic [7:0] adapt_boost,
	input wire logic miso_oe,
	input wire logic [7:0] boost_to_eq,
	input wire logic eq_full_bypass,
	input wire logic late_stage_bypass,
	input wire logic input0_detector_powerdown,
	input wire logic input1_detector_powerdown,
	input wire logic input0_eq_powerdown,
	input wire logic input1_eq_powerdown,
	input wire logic irq
);
	// ----
	// checks
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_full_bypass_cause: assert property (
		eq_full_bypass |-> $past(low_rate_detected) && !late_stage_bypass)
		else $error("full bypass without cause");
	chk_unsel_eq_pd: assert property (
		$past(selected_input) ? input0_eq_powerdown : input1_eq_powerdown)
		else $error("unselected equalizer powered");
	chk_late_idle: assert property (
		ss_n && $past(ss_n) && $past(ss_n, 2) && $past(ss_n, 3)
		|-> $stable(late_stage_bypass))
		else $error("late bypass moved while idle");
	chk_det_pd_idle: assert property (
		ss_n && $past(ss_n) && $past(ss_n, 2) && $past(ss_n, 3)
		|-> $stable({input0_detector_powerdown, input1_detector_powerdown}))
		else $error("detector powerdown moved while idle");
	chk_sel_eq_idle: assert property (
		(ss_n && !selected_input) [*4] |-> $stable(input0_eq_powerdown))
		else $error("selected powerdown moved while idle");
	chk_miso_in_frame: assert property (
		miso_oe |-> !$past(ss_n))
		else $error("miso driven outside frame");
	chk_irq_fall: assert property (
		$fell(irq) |-> !$past(ss_n) || !$past(ss_n, 2) || !$past(ss_n, 3))
		else $error("irq dropped without access");
	chk_boost_adapt: assert property (
		(adapt_running && $stable(adapt_boost)) [*3]
		|-> boost_to_eq == adapt_boost)
		else $error("boost does not follow adaptation");
endmodule

`default_nettype wire

// ### test/rxq_regs_tb_top.sv
// self-checking bench of the receive control bank
`timescale 1ns/10ps
`default_nettype none
`include "rxq_consts.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	num_errors++; $display("unexpected %0t %h %h", $time, a, b); end end

module rxq_regs_tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ss_n = 1'b1;
	logic sclk, mosi, cdr, d0, d1, eye, sel, lr, ar;
	logic [7:0] ab, boost_to_eq, q, v;
	logic [1:0] e;
	logic miso, miso_oe, eq_full_bypass, late_stage_bypass, irq, los_pin;
	logic input0_detector_powerdown, input1_detector_powerdown;
	logic input0_eq_powerdown, input1_eq_powerdown;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 82771;
	int evk [7] = '{6, 2, 4, 0, 5, 1, 3};
	logic [7:0] ofs [7] = '{`RXQ_OFS_BOOST, `RXQ_OFS_LOW_RATE,
		`RXQ_OFS_BYP_PD, `RXQ_OFS_IRQ_ENABLE, `RXQ_OFS_OVERRIDE,
		`RXQ_OFS_CHAN_CTRL, 8'h10};
	logic [7:0] rst [7] = '{`RXQ_RST_BOOST, `RXQ_RST_LOW_RATE,
		`RXQ_RST_BYP_PD, `RXQ_RST_IRQ_ENABLE, `RXQ_RST_OVERRIDE,
		`RXQ_RST_CHAN_CTRL, 8'h00};

	rxq_regs uut (.clk, .arst_n, .sclk, .ss_n, .mosi, .miso, .miso_oe,
		.cdr_locked(cdr), .input0_signal_detect(d0),
		.input1_signal_detect(d1), .eye_threshold_reached(eye),
		.selected_input(sel), .low_rate_detected(lr),
		.adapt_running(ar), .adapt_boost(ab), .boost_to_eq,
		.eq_full_bypass, .late_stage_bypass, .input0_detector_powerdown,
		.input1_detector_powerdown, .input0_eq_powerdown,
		.input1_eq_powerdown, .irq, .los_pin);

	always #5 clk = ~clk;

	// ----
	// helpers
	// ----
	function automatic logic exp_full(logic a, logic l, logic m);
		return a & l & ~m;
	endfunction

	function automatic logic [7:0] status_of(logic live, int k);
		return {live, 7'h01 << k};
	endfunction

	task automatic end_of_test();
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// sclk held 4 clk per phase, above the 2 clk minimum
	task automatic xfer(logic rdf, logic [7:0] a, logic [7:0] d,
		output logic [7:0] r);
		logic [15:0] f;
		f = {rdf, a[6:0], d};
		r = 8'h00;
		ss_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			mosi = f[i];
			repeat (4) @(negedge clk);
			if (i < 8)
				r = {r[6:0], miso};
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		ss_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		logic [7:0] r;
		xfer(1'b0, a, d, r);
	endtask

	task automatic rdc(logic [7:0] a, logic [7:0] x);
		logic [7:0] r;
		xfer(1'b1, a, 8'h00, r);
		`CHK(r, x)
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			end_of_test();
		end
	end

	// ----
	// main sequence
	// ----
	initial
	begin
		{sclk, mosi, cdr, d0, d1, eye, sel, lr, ar} = '0;
		ab = 8'h00;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(boost_to_eq, 8'h80)
		`CHK({input1_eq_powerdown, input0_eq_powerdown, los_pin}, 3'b101)
		for (int i = 0; i < 7; i++)
			rdc(ofs[i], rst[i]);
		for (int i = 0; i < 8; i++)
		begin
			v = 8'($random(seed));
			wr(ofs[i % 4], v);
			rdc(ofs[i % 4], v);
		end
		wr(`RXQ_OFS_BOOST, 8'h1b);
		`CHK(boost_to_eq, 8'h1b)
		rdc(`RXQ_OFS_DELIVERED, 8'h1b);
		for (int i = 0; i < 16; i++)
		begin
			v = 8'h90 | (8'($random(seed)) & 8'h68) | {6'h00, i[1], 1'b0};
			wr(`RXQ_OFS_LOW_RATE, {7'h00, i[0]});
			wr(`RXQ_OFS_BYP_PD, v);
			{sel, lr} = {i[3], i[2]};
			e = i[3] ? {v[3], 1'b1} : {1'b1, v[3]};
			repeat (2) @(negedge clk);
			`CHK(eq_full_bypass, exp_full(i[0], i[2], i[1]))
			`CHK(late_stage_bypass, v[1])
			`CHK({input0_detector_powerdown, input1_detector_powerdown}, v[6:5])
			`CHK({input1_eq_powerdown, input0_eq_powerdown}, e)
		end
		{sel, lr} = 2'b00;
		ar = 1'b1;
		ab = 8'($random(seed));
		repeat (4) @(negedge clk);
		`CHK(boost_to_eq, ab)
		rdc(`RXQ_OFS_BOOST, ab);
		wr(`RXQ_OFS_OVERRIDE, 8'h00);
		ar = 1'b0;
		ab = ab ^ 8'hff;
		repeat (2) @(negedge clk);
		`CHK(boost_to_eq, ab)
		rdc(`RXQ_OFS_DELIVERED, ab);
		rdc(`RXQ_OFS_BOOST, ab ^ 8'hff);
		// interrupt routed onto the loss pin until the detect-mode step below
		wr(`RXQ_OFS_CHAN_CTRL, 8'h20);
		xfer(1'b1, `RXQ_OFS_IRQ_STATUS, 8'h00, q);
		for (int s = 0; s < 7; s++)
		begin
			wr(`RXQ_OFS_IRQ_ENABLE, 8'h7f ^ (8'h01 << evk[s]));
			case (s)
				0: cdr = 1'b1;
				1: cdr = 1'b0;
				2: d0 = 1'b1;
				3: d0 = 1'b0;
				4: d1 = 1'b1;
				5: d1 = 1'b0;
				default: eye = 1'b1;
			endcase
			repeat (4) @(negedge clk);
			`CHK(irq, 1'b0)
			wr(`RXQ_OFS_IRQ_ENABLE, 8'h01 << evk[s]);
			`CHK({irq, los_pin}, 2'b11)
			rdc(`RXQ_OFS_IRQ_STATUS, status_of(d0, evk[s]));
			`CHK({irq, los_pin}, 2'b00)
		end
		// loss pin back to detect mode, second input selected
		wr(`RXQ_OFS_CHAN_CTRL, 8'h00);
		{sel, d1} = 2'b11;
		repeat (2) @(negedge clk);
		`CHK(los_pin, 1'b0)
		rdc(`RXQ_OFS_IRQ_STATUS, 8'ha0);
		// status is read-only, a write must not set flags
		wr(`RXQ_OFS_IRQ_STATUS, 8'h7f);
		rdc(`RXQ_OFS_IRQ_STATUS, 8'h80);
		end_of_test();
	end
endmodule

bind rxq_regs rxq_regs_asserts chk (.clk, .arst_n, .ss_n, .selected_input,
	.low_rate_detected, .adapt_running, .adapt_boost, .miso_oe,
	.boost_to_eq, .eq_full_bypass, .late_stage_bypass,
	.input0_detector_powerdown, .input1_detector_powerdown,
	.input0_eq_powerdown, .input1_eq_powerdown, .irq);

`default_nettype wire
